// ---- logic/eeprom_slave.sv ----
// Slave end of the two-wire EEPROM link
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Slave only, stepped by master's clock
// - Master alone starts transfers, supplies clock
// - START, select byte with direction, then acknowledge
// - Slave acknowledges ninth bit of received bytes
// - Master acknowledges each byte it reads but the last
// - Write ends STOP after ack; read after nack
// - Reset disables everything, bus ignored
// - Inhibit low allows writes, high refuses them
// - Unconnected inhibit counts as low
// - Inhibited: select, address acked; data not
// - Serial clock strobes every bit
// - Data line open drain: pull low, release
// - START: data falls while clock high
// - Watch for START except while programming
// - STOP: data rises while clock high, ends
// - Read ends in standby after nack, STOP
// - STOP closing a write starts programming
// - Sender releases after eight; receiver acks low
// - Select: type, zero enables, direction, MSB first
// - Sample on clock rise; change when low
// - Two address bytes, high first, each acked
// - Program only on STOP right after ack
module eeprom_slave #(
  parameter int unsigned WRITE_CYCLES = `WR_CYCLES_DEF,
  parameter logic [3:0] DEV_TYPE = 4'h6  // Arbitrary type code
) (
  input wire logic clk,
  input wire logic sys_rst,
  two_wire_if.slave bus,
  input wire logic write_inhibit,
  input wire eeprom_pkg::byte_t rd_data,
  output logic [15:0] mem_addr,
  output var eeprom_pkg::byte_t wr_data,
  output logic wr_valid,
  output logic rd_take,
  output logic write_start,
  output logic busy
);
  import eeprom_pkg::*;

  if (WRITE_CYCLES == 0) begin : g_bad_cycles
    $error("WRITE_CYCLES must be at least one");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic wi_m, wi_s;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_m <= 1'h1;
      scl_s <= 1'h1;
      scl_d <= 1'h1;
      sda_m <= 1'h1;
      sda_s <= 1'h1;
      sda_d <= 1'h1;
      wi_m <= 1'h0;
      wi_s <= 1'h0;
    end else begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      wi_m <= write_inhibit;
      wi_s <= wi_m;
    end
  end

  logic rise, fall, start_c, stop_c;
  assign rise = scl_s && !scl_d;
  assign fall = !scl_s && scl_d;
  assign start_c = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c = scl_s && scl_d && !sda_d && sda_s;

  // Drive low for a zero in the top bit
  function automatic logic low_for(input byte_t b);
    return !b[7];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Protocol state
  slave_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [1:0] bidx, next_bidx;
  byte_t sr, next_sr, tx, next_tx, next_wdata;
  logic rw, next_rw, inh, next_inh, oe, next_oe, pend, next_pend;
  logic [31:0] wcnt, next_wcnt;
  logic [15:0] next_addr;
  logic next_wr_valid, next_rd_take, next_write_start, next_busy;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bidx = bidx;
    next_sr = sr;
    next_tx = tx;
    next_rw = rw;
    next_inh = inh;
    next_oe = oe;
    next_pend = pend;
    next_wcnt = wcnt;
    next_addr = mem_addr;
    next_wdata = wr_data;
    next_wr_valid = 1'h0;
    next_rd_take = 1'h0;
    next_write_start = 1'h0;
    if (state == S_BUSY) begin
      // Bus is not watched at all while programming
      next_oe = 1'h0;
      if (wcnt == `ONE_CYCLE) next_state = S_IDLE;
      else next_wcnt = wcnt - `ONE_CYCLE;
    end else if (start_c) begin
      // Also a repeated start in mid-transfer
      next_state = S_RECV;
      next_cnt = `NO_BITS;
      next_bidx = `SEL_BYTE;
      next_oe = 1'h0;
      next_pend = 1'h0;
      next_inh = wi_s;
    end else if (stop_c) begin
      next_oe = 1'h0;
      if (state == S_RECV && cnt == `STOP_BITS && pend) begin
        next_state = S_BUSY;
        next_wcnt = WRITE_CYCLES;
        next_write_start = 1'h1;
      end else begin
        next_state = S_IDLE;
      end
      next_pend = 1'h0;
    end else begin
      unique case (state)
        S_IDLE: ;
        S_RECV: begin
          if (rise) begin
            next_sr = {sr[6:0], sda_s};
            next_cnt = cnt + 4'h1;
            if (bidx != `DATA_BYTE) next_inh = inh || wi_s;
          end else if (fall && cnt == `BYTE_BITS) begin
            next_state = S_ACK;
            next_oe = 1'h1;
            unique case (bidx)
              `SEL_BYTE: begin
                if (sr[7:1] == {DEV_TYPE, `CE_CODE}) begin
                  next_rw = sr[0];
                end else begin
                  next_state = S_IDLE;
                  next_oe = 1'h0;
                end
              end
              `AHI_BYTE: next_addr[15:8] = sr;
              `ALO_BYTE: next_addr[7:0] = sr;
              `DATA_BYTE: begin
                if (inh) begin
                  next_oe = 1'h0;
                end else begin
                  next_wdata = sr;
                  next_wr_valid = 1'h1;
                  next_pend = 1'h1;
                  next_addr = mem_addr + 16'h0001;
                end
              end
            endcase
          end
        end
        S_ACK: begin
          if (fall) begin
            next_oe = 1'h0;
            next_cnt = `NO_BITS;
            if (bidx == `SEL_BYTE && rw) begin
              next_state = S_SEND;
              next_tx = rd_data;
              next_rd_take = 1'h1;
              next_oe = low_for(rd_data);
            end else begin
              next_state = S_RECV;
              if (bidx != `DATA_BYTE) next_bidx = bidx + 2'h1;
            end
          end
        end
        S_SEND: begin
          if (rise) begin
            next_cnt = cnt + 4'h1;
          end else if (fall) begin
            if (cnt == `BYTE_BITS) begin
              next_state = S_MACK;
              next_oe = 1'h0;
              next_addr = mem_addr + 16'h0001;
            end else begin
              next_tx = {tx[6:0], 1'h0};
              next_oe = low_for({tx[6:0], 1'h0});
            end
          end
        end
        S_MACK: begin
          if (rise && sda_s) begin
            // Master refused: drop off the bus until next start
            next_state = S_IDLE;
          end else if (fall) begin
            next_state = S_SEND;
            next_cnt = `NO_BITS;
            next_tx = rd_data;
            next_rd_take = 1'h1;
            next_oe = low_for(rd_data);
          end
        end
        S_BUSY: ;
        default: next_state = S_IDLE;
      endcase
    end
    next_busy = (next_state == S_BUSY);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      cnt <= `NO_BITS;
      bidx <= `SEL_BYTE;
      sr <= '0;
      tx <= '0;
      rw <= 1'h0;
      inh <= 1'h0;
      oe <= 1'h0;
      pend <= 1'h0;
      wcnt <= '0;
      mem_addr <= '0;
      wr_data <= '0;
      wr_valid <= 1'h0;
      rd_take <= 1'h0;
      write_start <= 1'h0;
      busy <= 1'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bidx <= next_bidx;
      sr <= next_sr;
      tx <= next_tx;
      rw <= next_rw;
      inh <= next_inh;
      oe <= next_oe;
      pend <= next_pend;
      wcnt <= next_wcnt;
      mem_addr <= next_addr;
      wr_data <= next_wdata;
      wr_valid <= next_wr_valid;
      rd_take <= next_rd_take;
      write_start <= next_write_start;
      busy <= next_busy;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Open-drain pin: value is always low, only the enable moves
  logic sda_o;
  always_ff @(posedge clk) begin
    sda_o <= 1'h0;
  end
  assign bus.s_sda_o = sda_o;
  assign bus.s_sda_oe = oe;

endmodule  // eeprom_slave

`default_nettype wire

// ---- logic/eeprom_consts.svh ----
// Shared constants for the two-wire EEPROM link
`ifndef EEPROM_LINK_CONSTS_SVH
`define EEPROM_LINK_CONSTS_SVH

// Byte position within a command
`define SEL_BYTE 2'h0
`define AHI_BYTE 2'h1
`define ALO_BYTE 2'h2
`define DATA_BYTE 2'h3

// Bit counts and fixed select fields
`define BYTE_BITS 4'h8
`define NO_BITS 4'h0
// A STOP follows one clock rise of the slot after the acknowledge
`define STOP_BITS 4'h1
`define MSB_BIT 3'h7
`define LSB_BIT 3'h0
`define CE_CODE 3'h0
`define ONE_CYCLE 32'h0000_0001

// Quarter steps of one bit time on the master side
`define Q_SET 2'h0
`define Q_RISE 2'h1
`define Q_MID 2'h2
`define Q_FALL 2'h3

// Default counts
`define WR_CYCLES_DEF 1000
`define QUARTER_DEF 4
`define FIFO_DEPTH_DEF 8

`endif

// ---- logic/eeprom_pkg.sv ----
// Types shared by both ends of the two-wire EEPROM link
package eeprom_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RECV = 3'b001,
    S_ACK = 3'b010,
    S_SEND = 3'b011,
    S_MACK = 3'b100,
    S_BUSY = 3'b101
  } slave_state_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BIT = 3'b010,
    M_ACK = 3'b011,
    M_STOP = 3'b100
  } master_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rd;
    byte_t data;
  } cmd_t;

endpackage

// ---- logic/two_wire_if.sv ----
// Two-wire link between the bus master and the EEPROM slave
`timescale 1ns/100ps
`default_nettype none

interface two_wire_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // Pull-up: the line is low only while some end drives a low
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

`default_nettype wire

// ---- logic/bus_master.sv ----
// Master end of the two-wire EEPROM link with its command FIFO
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Command FIFO

module cmd_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = `FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic next_in_ready, push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];

  always_comb begin
    next_wp = push ? wp + AW'(1) : wp;
    next_rp = pop ? rp + AW'(1) : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Registered ready keeps the port flop-driven
    next_in_ready = (next_cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready <= 1'h1;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      in_ready <= next_in_ready;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

endmodule  // cmd_fifo

////////////////////////////////////////////////////////////////////////////////
// Bus master: makes the serial clock, shifts bytes from the FIFO

module bus_master #(
  parameter int unsigned QUARTER = `QUARTER_DEF,
  parameter int unsigned FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  two_wire_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire eeprom_pkg::cmd_t cmd,
  output var eeprom_pkg::byte_t rx_data,
  output logic rx_valid,
  output logic ack_ok,
  output logic byte_done,
  output logic link_busy
);
  import eeprom_pkg::*;

  // Below four the slave's sampled ack may not be settled in time
  if (QUARTER < 4) begin : g_bad_quarter
    $error("QUARTER must be at least four");
  end

  localparam int unsigned TW = $clog2(QUARTER + 1);
  localparam logic [TW-1:0] TLAST = TW'(QUARTER - 1);

  cmd_t f_data;
  logic f_valid, f_pop;

  cmd_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  logic sda_m, sda_s;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_m <= 1'h1;
      sda_s <= 1'h1;
    end else begin
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  master_state_t state, next_state;
  logic [TW-1:0] tdiv, next_tdiv;
  logic [1:0] q, next_q;
  logic [2:0] bitn, next_bitn;
  cmd_t word, next_word;
  byte_t rx_sr, next_rx_sr, next_rx_data;
  logic scl, next_scl, oe, next_oe, tick;
  logic next_rx_valid, next_ack_ok, next_done, next_busy;

  assign tick = (tdiv == TLAST);

  always_comb begin
    next_state = state;
    next_tdiv = tick ? '0 : tdiv + {{(TW-1){1'b0}}, 1'b1};
    next_q = q;
    next_bitn = bitn;
    next_word = word;
    next_rx_sr = rx_sr;
    next_rx_data = rx_data;
    next_scl = scl;
    next_oe = oe;
    next_rx_valid = 1'h0;
    next_ack_ok = ack_ok;
    next_done = 1'h0;
    f_pop = 1'h0;
    if (state == M_IDLE) begin
      if (f_valid) begin
        // Only this end opens a transfer
        f_pop = 1'h1;
        next_word = f_data;
        next_state = f_data.start ? M_START : M_BIT;
        next_q = `Q_SET;
        next_bitn = `MSB_BIT;
        next_tdiv = '0;
      end
    end else if (tick) begin
      next_q = q + 2'h1;
      unique case (state)
        M_START: begin
          unique case (q)
            `Q_SET: begin
              next_oe = 1'h0;
              next_scl = 1'h0;
            end
            `Q_RISE: next_scl = 1'h1;
            `Q_MID: next_oe = 1'h1;
            `Q_FALL: begin
              next_scl = 1'h0;
              next_state = M_BIT;
            end
          endcase
        end
        M_BIT: begin
          unique case (q)
            `Q_SET: next_oe = !word.rd && !word.data[bitn];
            `Q_RISE: next_scl = 1'h1;
            `Q_MID: if (word.rd) next_rx_sr = {rx_sr[6:0], sda_s};
            `Q_FALL: begin
              next_scl = 1'h0;
              if (bitn == `LSB_BIT) next_state = M_ACK;
              else next_bitn = bitn - 3'h1;
            end
          endcase
        end
        M_ACK: begin
          unique case (q)
            `Q_SET: next_oe = word.rd && !word.stop;
            `Q_RISE: next_scl = 1'h1;
            `Q_MID: if (!word.rd) next_ack_ok = !sda_s;
            `Q_FALL: begin
              next_scl = 1'h0;
              next_done = 1'h1;
              next_rx_valid = word.rd;
              next_rx_data = rx_sr;
              next_state = word.stop ? M_STOP : M_IDLE;
            end
          endcase
        end
        M_STOP: begin
          unique case (q)
            `Q_SET: next_oe = 1'h1;
            `Q_RISE: next_scl = 1'h1;
            `Q_MID: next_oe = 1'h0;
            `Q_FALL: next_state = M_IDLE;
          endcase
        end
        default: next_state = M_IDLE;
      endcase
    end
    next_busy = (next_state != M_IDLE);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= M_IDLE;
      tdiv <= '0;
      q <= `Q_SET;
      bitn <= `MSB_BIT;
      word <= '0;
      rx_sr <= '0;
      rx_data <= '0;
      scl <= 1'h1;
      oe <= 1'h0;
      rx_valid <= 1'h0;
      ack_ok <= 1'h0;
      byte_done <= 1'h0;
      link_busy <= 1'h0;
    end else begin
      state <= next_state;
      tdiv <= next_tdiv;
      q <= next_q;
      bitn <= next_bitn;
      word <= next_word;
      rx_sr <= next_rx_sr;
      rx_data <= next_rx_data;
      scl <= next_scl;
      oe <= next_oe;
      rx_valid <= next_rx_valid;
      ack_ok <= next_ack_ok;
      byte_done <= next_done;
      link_busy <= next_busy;
    end
  end

  logic sda_o;
  always_ff @(posedge clk) begin
    sda_o <= 1'h0;
  end

  assign bus.scl = scl;
  assign bus.m_sda_o = sda_o;
  assign bus.m_sda_oe = oe;

endmodule  // bus_master

`default_nettype wire

// ---- sim/link_asserts.sv ----
// Assertions on the two-wire link between master and slave
`timescale 1ns/100ps
`default_nettype none

module link_asserts #(
  parameter int unsigned WRITE_CYCLES = 1000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_o,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic busy,
  input wire logic write_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers: age of the last wire STOP (saturates) and length of the busy spell
  logic prev_scl;
  logic prev_sda;
  logic [7:0] stop_age;
  logic [15:0] busy_len;
  always_ff @(posedge clk) begin
    prev_scl <= scl;
    prev_sda <= sda;
    busy_len <= busy ? busy_len + 16'h0001 : 16'h0000;
    if (sys_rst) begin
      stop_age <= 8'hff;
    end else if (scl && prev_scl && sda && !prev_sda) begin
      stop_age <= 8'h00;
    end else if (stop_age != 8'hff) begin
      stop_age <= stop_age + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  drive_low_a: assert property (s_sda_o == 1'b0 && m_sda_o == 1'b0)
    else $error("data line driven high");
  reset_quiet_a: assert property ($fell(sys_rst) |-> !s_sda_oe && !busy)
    else $error("slave active right after reset");
  busy_quiet_a: assert property (busy |-> !s_sda_oe)
    else $error("slave answers while programming");
  turn_low_a: assert property ($changed(s_sda_oe) |-> !scl && !prev_scl)
    else $error("slave changed data with clock high");
  stop_first_a: assert property (write_start |-> stop_age < 8'h10)
    else $error("write cycle without a stop");
  start_busy_a: assert property (write_start |=> busy [*8])
    else $error("write cycle not held busy");
  busy_len_a: assert property ($fell(busy) |-> busy_len == WRITE_CYCLES)
    else $error("write cycle length wrong");
  no_restart_a: assert property (busy && $past(busy) |-> !write_start)
    else $error("write restarted while busy");

  cover property (write_start);
  cover property ($rose(s_sda_oe) && !busy);
  cover property ($fell(busy));
endmodule  // link_asserts

`default_nettype wire

// ---- sim/tb_serial_eeprom_bus_slave_front_end.sv ----
// Testbench: bus master and EEPROM slave joined over the two-wire link
`timescale 1ns/100ps
`default_nettype none

module tb_serial_eeprom_bus_slave_front_end;
  import eeprom_pkg::*;
  localparam int unsigned WCYC = 600;
  localparam logic [3:0] DEV = 4'h9;  // Arbitrary type code
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic write_inhibit = 1'b0;
  cmd_t cmd = '0;
  byte_t rd_data = 8'h00;
  logic cmd_ready, rx_valid, ack_ok, byte_done, link_busy, wr_valid, rd_take, write_start, busy;
  byte_t rx_data, wr_data, sel, wsh, wire_sel;
  logic [15:0] mem_addr;
  int n_fail = 0;
  int n_tests = 0;
  int n_ws = 0;
  int n_take = 0;
  int nbit = 9;
  logic saw_full = 1'b0;
  logic sq = 1'b1;
  logic dq = 1'b1;
  logic [31:0] seed = 32'he52b;
  logic [8:0] byte_q[$];
  logic [23:0] wr_q[$];

  always #5 clk = ~clk;

  two_wire_if i_two_wire_if ();
  bus_master #(.QUARTER(4), .FIFO_DEPTH(8)) i_bus_master (.clk, .sys_rst,
    .bus(i_two_wire_if.master), .cmd_valid, .cmd_ready, .cmd, .rx_data, .rx_valid, .ack_ok,
    .byte_done, .link_busy);
  eeprom_slave #(.WRITE_CYCLES(WCYC), .DEV_TYPE(DEV)) i_eeprom_slave (.clk, .sys_rst,
    .bus(i_two_wire_if.slave), .write_inhibit, .rd_data, .mem_addr, .wr_data, .wr_valid,
    .rd_take, .write_start, .busy);
  link_asserts #(.WRITE_CYCLES(WCYC)) i_link_asserts (.clk, .sys_rst,
    .scl(i_two_wire_if.scl), .sda(i_two_wire_if.sda), .m_sda_o(i_two_wire_if.m_sda_o),
    .s_sda_o(i_two_wire_if.s_sda_o), .s_sda_oe(i_two_wire_if.s_sda_oe), .busy, .write_start);

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Every wait is bounded; a hang ends the run
  task automatic tick(inout int g);
    @(posedge clk);
    g++;
    if (g > 20000) begin
      n_fail++;
      $display("[ERR] wait expected done seen timeout");
      give_verdict();
    end
  endtask

  task automatic send(input logic opn, input logic cls, input logic rd, input byte_t d,
                      input logic [8:0] note);
    int g;
    g = 0;
    cmd_valid <= 1'b1;
    cmd <= '{start: opn, stop: cls, rd: rd, data: d};
    byte_q.push_back(note);
    do tick(g); while (cmd_ready !== 1'b1);
  endtask

  task automatic drain(input string name);
    int g;
    g = 0;
    cmd_valid <= 1'b0;
    do tick(g); while (byte_q.size() != 0 || link_busy !== 1'b0);
    check("idle lines", {i_two_wire_if.scl, i_two_wire_if.sda}, 16'h0003);
    $display("test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitors: notes taken from the queues as results appear
  always @(posedge clk) begin
    rd_data <= mem_addr[7:0] ^ 8'h5a;
    if (cmd_ready === 1'b0) saw_full = 1'b1;
    if (write_start === 1'b1) n_ws++;
    if (rd_take === 1'b1) n_take++;
  end

  always @(posedge clk) begin
    logic [8:0] nt;
    if (byte_done === 1'b1) begin
      nt = (byte_q.size() != 0) ? byte_q.pop_front() : 9'h1ff;
      check("rx_valid", {15'h0000, rx_valid}, {15'h0000, nt[8]});
      @(posedge clk);
      if (nt[8]) check("rx_data", {8'h00, rx_data}, {8'h00, nt[7:0]});
      else check("ack_ok", {15'h0000, ack_ok}, {15'h0000, nt[0]});
    end
  end

  always @(posedge clk) begin
    logic [23:0] wn;
    if (wr_valid === 1'b1) begin
      wn = (wr_q.size() != 0) ? wr_q.pop_front() : 24'hffff_ff;
      check("wr_data", {8'h00, wr_data}, {8'h00, wn[7:0]});
      check("mem_addr", mem_addr, wn[23:8]);
    end
  end

  // Wire view: first byte after each START, shifted in on clock rises
  always @(posedge clk) begin
    if (sq && i_two_wire_if.scl && dq && !i_two_wire_if.sda) nbit = 0;
    else if (!sq && i_two_wire_if.scl && nbit < 8) begin
      wsh = {wsh[6:0], i_two_wire_if.sda};
      nbit++;
      if (nbit == 8) wire_sel = wsh;
    end
    sq = i_two_wire_if.scl;
    dq = i_two_wire_if.sda;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [15:0] addr;
    byte_t d0;
    byte_t d1;
    int g;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    seed = xorshift(seed);
    addr = seed[15:0];
    d0 = seed[23:16];
    seed = xorshift(seed);
    d1 = seed[7:0];
    sel = {DEV, 3'h0, 1'b0};
    // Byte write pair, address high then low
    send(1'b1, 1'b0, 1'b0, sel, 9'h001);
    send(1'b0, 1'b0, 1'b0, addr[15:8], 9'h001);
    send(1'b0, 1'b0, 1'b0, addr[7:0], 9'h001);
    wr_q.push_back({addr + 16'h0001, d0});
    send(1'b0, 1'b0, 1'b0, d0, 9'h001);
    wr_q.push_back({addr + 16'h0002, d1});
    send(1'b0, 1'b1, 1'b0, d1, 9'h001);
    drain("write");
    g = 0;
    do tick(g); while (busy !== 1'b1);
    // Poll during the write cycle is refused, then accepted
    send(1'b1, 1'b1, 1'b0, sel, 9'h000);
    drain("poll busy");
    g = 0;
    do tick(g); while (busy !== 1'b0);
    send(1'b1, 1'b1, 1'b0, sel, 9'h001);
    drain("poll ready");
    // Sequential read fills the command buffer; last byte nacked
    send(1'b1, 1'b0, 1'b0, {DEV, 3'h0, 1'b1}, 9'h001);
    for (int i = 0; i < 9; i++) begin
      send(1'b0, i == 8, 1'b1, 8'h00, {1'b1, (addr[7:0] + 8'h02 + 8'(i)) ^ 8'h5a});
    end
    drain("read");
    check("buffer full seen", {15'h0000, saw_full}, 16'h0001);
    check("reads taken", 16'(n_take), 16'h0009);
    // Inhibited write: data byte refused, no write cycle
    write_inhibit <= 1'b1;
    send(1'b1, 1'b0, 1'b0, sel, 9'h001);
    send(1'b0, 1'b0, 1'b0, addr[15:8], 9'h001);
    send(1'b0, 1'b0, 1'b0, addr[7:0], 9'h001);
    send(1'b0, 1'b1, 1'b0, d0, 9'h000);
    drain("inhibit");
    write_inhibit <= 1'b0;
    // Every select bit but direction flipped: no acknowledge
    for (int b = 1; b < 8; b++) begin
      send(1'b1, 1'b1, 1'b0, sel ^ (8'h01 << b), 9'h000);
      drain("bad select");
      check("wire select", {8'h00, wire_sel}, {8'h00, sel ^ (8'h01 << b)});
    end
    check("write cycles", 16'(n_ws), 16'h0001);
    give_verdict();
  end
endmodule  // tb_serial_eeprom_bus_slave_front_end

`default_nettype wire
